// >>> aoq_defines.svh
`ifndef AOQ_DEFINES_SVH
`define AOQ_DEFINES_SVH

// ----------------------------------------
// Register offsets (word index within a channel; byte addresses for the shared registers)
// ----------------------------------------
`define AOQ_OFF_CFG 2'h0
`define AOQ_OFF_HIGH 2'h1
`define AOQ_OFF_LOW 2'h2
`define AOQ_OFF_HYST 2'h3
`define AOQ_OFF_SETPT 8'h40
`define AOQ_OFF_STATUS 8'h44
`define AOQ_OFF_CONTROL 8'h48
`define AOQ_CH_SPAN 8'h40

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define AOQ_CFG_BITS 9
`define AOQ_CTL_CLR_BIT 0
`define AOQ_RST_SETVAL 16'h060e
`define AOQ_RST_HYST 16'h0001
`define AOQ_HYST_MIN 16'h0001
`define AOQ_HYST_MAX_H 16'h0064
`define AOQ_HYST_MAX_L 16'h03e8
`define AOQ_EXT_MAX 16'h7fff
`define AOQ_EXT_MIN 16'h8000
`define AOQ_RESP_OKAY 2'h0
`define AOQ_RESP_SLVERR 2'h2

`endif

// >>> aoq_pkg.sv
`default_nettype none
package aoq_pkg;

  // Comparison modes
  typedef enum logic [3:0] {
    AOQ_MD_OFF = 4'b0000,
    AOQ_MD_DEV_HI = 4'b0001,
    AOQ_MD_DEV_LO = 4'b0010,
    AOQ_MD_DEV_BAND = 4'b0011,
    AOQ_MD_DEV_REV = 4'b0100,
    AOQ_MD_ABS_HI = 4'b0101,
    AOQ_MD_ABS_LO = 4'b0110,
    AOQ_MD_LOOP = 4'b0111,
    AOQ_MD_SENSOR = 4'b1000,
    AOQ_MD_HEATER = 4'b1001
  } aoq_mode_e;

  // Output options
  typedef enum logic [2:0] {
    AOQ_OPT_STANDARD = 3'b000,
    AOQ_OPT_LATCH = 3'b001,
    AOQ_OPT_SB1 = 3'b010,
    AOQ_OPT_LATCH_SB1 = 3'b011,
    AOQ_OPT_SB2 = 3'b100,
    AOQ_OPT_LATCH_SB2 = 3'b101
  } aoq_opt_e;

  typedef struct packed {
    logic fine;
    logic nc;
    aoq_opt_e opt;
    aoq_mode_e mode;
  } aoq_cfg_s;

  typedef struct packed {
    aoq_cfg_s cfg;
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic [15:0] hyst;
  } aoq_chan_s;

  typedef struct packed {
    logic boot;
    logic pend;
    logic latched;
    logic active;
    logic relay;
    logic led;
  } aoq_qual_s;

  typedef struct packed {
    logic signed [15:0] pv;
    logic signed [15:0] heater;
  } aoq_meas_s;

  typedef aoq_meas_s [3:0] aoq_meas_arr_t;

endpackage
`default_nettype wire

// >>> aoq_sync.sv
`default_nettype none
module aoq_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  import aoq_pkg::*;

  // Three stages; the output moves once stages two and three agree
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic out;
  } aoq_sync_s;

  aoq_sync_s s_r;
  aoq_sync_s s_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ff1 = din;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    if (s_r.ff2 == s_r.ff3) begin
      s_nxt.out = s_r.ff3;
    end
  end

  // Synchronous reset to constants only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.out;
endmodule // aoq_sync
`default_nettype wire

// >>> aoq_cmp.sv
`default_nettype none
module aoq_cmp (
  input wire logic aclk,
  input wire logic aresetn,
  input wire aoq_pkg::aoq_mode_e mode,
  input wire logic signed [15:0] pv,
  input wire logic signed [15:0] sv,
  input wire logic signed [15:0] hi,
  input wire logic signed [15:0] lo,
  input wire logic [15:0] hyst,
  input wire logic signed [15:0] heater,
  input wire logic loop_break,
  input wire logic sensor_break,
  output logic cond
);
  import aoq_pkg::*;

  typedef struct packed {
    logic cond;
  } aoq_cmp_s;

  aoq_cmp_s s_r;
  aoq_cmp_s s_nxt;

  // Widened so that threshold plus band never wraps
  function automatic logic signed [17:0] ext(input logic [15:0] v);
    ext = $signed({{2{v[15]}}, v});
  endfunction

  // Rise above t; once on, fall only at or below t - h
  function automatic logic over(input logic signed [17:0] x,
      input logic signed [17:0] t, input logic signed [17:0] h,
      input logic prev);
    over = prev ? (x > t - h) : (x > t);
  endfunction

  // Fall below t; once on, clear only at or above t + h
  function automatic logic under(input logic signed [17:0] x,
      input logic signed [17:0] t, input logic signed [17:0] h,
      input logic prev);
    under = prev ? (x < t + h) : (x < t);
  endfunction

  // ----------------------------------------
  // Comparison
  // ----------------------------------------
  always_comb begin
    logic signed [17:0] d;
    logic signed [17:0] h;
    logic p;
    d = ext(pv) - ext(sv);
    h = $signed({2'b00, hyst});
    p = s_r.cond;
    s_nxt = s_r;
    case (mode)
      AOQ_MD_DEV_HI: s_nxt.cond = over(d, ext(hi), h, p);
      AOQ_MD_DEV_LO: s_nxt.cond = under(d, -ext(hi), h, p);
      AOQ_MD_DEV_BAND: begin
        s_nxt.cond = over(d, ext(hi), h, p) | under(d, -ext(lo), h, p);
      end
      AOQ_MD_DEV_REV: begin
        s_nxt.cond = p ? (d <= ext(hi) + h && d >= -ext(lo) - h)
                       : (d <= ext(hi) && d >= -ext(lo));
      end
      AOQ_MD_ABS_HI: s_nxt.cond = over(ext(pv), ext(hi), h, p);
      AOQ_MD_ABS_LO: s_nxt.cond = under(ext(pv), ext(lo), h, p);
      // Same band treatment as temperature compares
      AOQ_MD_HEATER: s_nxt.cond = under(ext(heater), ext(lo), h, p);
      // Break detectors pass straight through, no band
      AOQ_MD_LOOP: s_nxt.cond = loop_break;
      AOQ_MD_SENSOR: s_nxt.cond = sensor_break;
      default: s_nxt.cond = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cond = s_r.cond;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_abs_hold;
    (mode == AOQ_MD_ABS_HI && cond
      && ext(pv) > ext(hi) - $signed({2'b00, hyst})) |=> cond;
  endproperty
  a_abs_hold: assert property (p_abs_hold)
    else $error("absolute alarm dropped inside band");

  property p_heater_hold;
    (mode == AOQ_MD_HEATER && cond
      && ext(heater) < ext(lo) + $signed({2'b00, hyst})) |=> cond;
  endproperty
  a_heater_hold: assert property (p_heater_hold)
    else $error("heater alarm dropped inside band");

  property p_loop_direct;
    (mode == AOQ_MD_LOOP) |=> (cond == $past(loop_break));
  endproperty
  a_loop_direct: assert property (p_loop_direct)
    else $error("loop break not passed directly");
endmodule // aoq_cmp
`default_nettype wire

// >>> aoq_alarm_qualifier.sv
`include "aoq_defines.svh"
`default_nettype none
module aoq_alarm_qualifier (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire aoq_pkg::aoq_meas_arr_t meas,
  input wire logic [3:0] loop_break,
  input wire logic [3:0] sensor_break,
  input wire logic alarm_reset_pin,
  input wire logic run_pin,
  output logic [3:0] relay_close,
  output logic [3:0] indicator
);
  import aoq_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic aw_have; // Write address held
    logic [7:0] awaddr;
    logic w_have; // Write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic signed [15:0] setpoint;
    logic run_q; // Last run level, for stop-to-run edge
    aoq_chan_s [3:0] ch;
    aoq_qual_s [3:0] q;
  } aoq_main_s;

  aoq_main_s s_r;
  aoq_main_s s_nxt;

  logic [3:0] cond; // Raw comparator results
  logic clr_pin; // Synchronised alarm reset request
  logic run_s; // Synchronised run level
  logic clr_c; // Alarm reset this cycle, pin or software
  logic rearm_c; // Standby two re-arm event this cycle
  logic [3:0] modechg_c; // Mode or option changed on a channel

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = st[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // Extremes that cannot trigger in the given mode
  function automatic logic [15:0] ext_hi(input aoq_mode_e m);
    ext_hi = (m == AOQ_MD_DEV_REV) ? `AOQ_EXT_MIN : `AOQ_EXT_MAX;
  endfunction

  function automatic logic [15:0] ext_lo(input aoq_mode_e m);
    ext_lo = (m == AOQ_MD_ABS_LO || m == AOQ_MD_HEATER
      || m == AOQ_MD_DEV_REV) ? `AOQ_EXT_MIN : `AOQ_EXT_MAX;
  endfunction

  // Band held within its legal range for the resolution
  function automatic logic [15:0] clamp_hyst(input logic [15:0] v,
      input logic fine);
    logic [15:0] mx;
    mx = fine ? `AOQ_HYST_MAX_L : `AOQ_HYST_MAX_H;
    if (v < `AOQ_HYST_MIN) begin
      clamp_hyst = `AOQ_HYST_MIN;
    end else if (v > mx) begin
      clamp_hyst = mx;
    end else begin
      clamp_hyst = v;
    end
  endfunction

  // Break detectors hide the band entirely
  function automatic logic no_band(input aoq_mode_e m);
    no_band = (m == AOQ_MD_LOOP || m == AOQ_MD_SENSOR);
  endfunction

  // ----------------------------------------
  // Pin synchronisers and comparators
  // ----------------------------------------
  aoq_sync u_sync_clr (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(alarm_reset_pin),
    .dout(clr_pin)
  );

  aoq_sync u_sync_run (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(run_pin),
    .dout(run_s)
  );

  for (genvar g = 0; g < 4; g++) begin : g_cmp
    aoq_cmp u_cmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode(s_r.ch[g].cfg.mode),
      .pv(meas[g].pv),
      .sv(s_r.setpoint),
      .hi(s_r.ch[g].hi),
      .lo(s_r.ch[g].lo),
      .hyst(s_r.ch[g].hyst),
      .heater(meas[g].heater),
      .loop_break(loop_break[g]),
      .sensor_break(sensor_break[g]),
      .cond(cond[g])
    );
  end

  // Handshake readies: one write and one read in flight
  assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] m;
    logic [1:0] ci;
    aoq_cfg_s nc;
    aoq_opt_e op;
    logic lat;
    logic sb;
    logic qual;
    m = '0;
    ci = '0;
    nc = '0;
    op = AOQ_OPT_STANDARD;
    lat = 1'b0;
    sb = 1'b0;
    qual = 1'b0;
    s_nxt = s_r;
    clr_c = clr_pin;
    modechg_c = '0;
    // Stop-to-run counts as a re-arm event
    rearm_c = run_s && !s_r.run_q;
    s_nxt.run_q = run_s;

    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `AOQ_RESP_OKAY;
      ci = s_r.awaddr[5:4];
      if (s_r.awaddr < `AOQ_CH_SPAN) begin
        // Any parameter write re-arms standby two
        rearm_c = 1'b1;
        case (s_r.awaddr[3:2])
          `AOQ_OFF_CFG: begin
            m = merge({23'h0, s_r.ch[ci].cfg}, s_r.wdata, s_r.wstrb);
            nc = aoq_cfg_s'(m[`AOQ_CFG_BITS-1:0]);
            s_nxt.ch[ci].cfg = nc;
            if (nc.mode != s_r.ch[ci].cfg.mode
                || nc.opt != s_r.ch[ci].cfg.opt) begin
              modechg_c[ci] = 1'b1;
              s_nxt.ch[ci].hi = ext_hi(nc.mode);
              s_nxt.ch[ci].lo = ext_lo(nc.mode);
            end
            s_nxt.ch[ci].hyst = clamp_hyst(s_r.ch[ci].hyst, nc.fine);
          end
          `AOQ_OFF_HIGH: begin
            m = merge({16'h0, s_r.ch[ci].hi}, s_r.wdata, s_r.wstrb);
            s_nxt.ch[ci].hi = m[15:0];
          end
          `AOQ_OFF_LOW: begin
            m = merge({16'h0, s_r.ch[ci].lo}, s_r.wdata, s_r.wstrb);
            s_nxt.ch[ci].lo = m[15:0];
          end
          default: begin
            m = merge({16'h0, s_r.ch[ci].hyst}, s_r.wdata, s_r.wstrb);
            // Each output keeps its own band
            s_nxt.ch[ci].hyst =
              clamp_hyst(m[15:0], s_r.ch[ci].cfg.fine);
          end
        endcase
      end else if (s_r.awaddr == `AOQ_OFF_SETPT) begin
        m = merge({16'h0, s_r.setpoint}, s_r.wdata, s_r.wstrb);
        s_nxt.setpoint = m[15:0];
        rearm_c = 1'b1;
      end else if (s_r.awaddr == `AOQ_OFF_CONTROL) begin
        // Self-clearing software alarm reset
        clr_c = clr_pin
          || (s_r.wstrb[0] && s_r.wdata[`AOQ_CTL_CLR_BIT]);
      end else if (s_r.awaddr != `AOQ_OFF_STATUS) begin
        s_nxt.bresp = `AOQ_RESP_SLVERR;
      end
    end

    // Reads answer in the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `AOQ_RESP_OKAY;
      s_nxt.rdata = '0;
      ci = s_axi_araddr[5:4];
      if (s_axi_araddr < `AOQ_CH_SPAN) begin
        case (s_axi_araddr[3:2])
          `AOQ_OFF_CFG: s_nxt.rdata = {23'h0, s_r.ch[ci].cfg};
          `AOQ_OFF_HIGH: s_nxt.rdata = {16'h0, s_r.ch[ci].hi};
          `AOQ_OFF_LOW: s_nxt.rdata = {16'h0, s_r.ch[ci].lo};
          default: begin
            if (!no_band(s_r.ch[ci].cfg.mode)) begin
              s_nxt.rdata = {16'h0, s_r.ch[ci].hyst};
            end
          end
        endcase
      end else if (s_axi_araddr == `AOQ_OFF_SETPT) begin
        s_nxt.rdata = {16'h0, s_r.setpoint};
      end else if (s_axi_araddr == `AOQ_OFF_STATUS) begin
        for (int i = 0; i < 4; i++) begin
          s_nxt.rdata[i] = cond[i];
          s_nxt.rdata[4 + i] = s_r.q[i].active;
          s_nxt.rdata[8 + i] = s_r.q[i].pend;
          s_nxt.rdata[12 + i] = s_r.q[i].latched;
        end
      end else if (s_axi_araddr != `AOQ_OFF_CONTROL) begin
        s_nxt.rresp = `AOQ_RESP_SLVERR;
      end
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Per-channel qualification, each on its own option
    for (int i = 0; i < 4; i++) begin
      op = s_r.ch[i].cfg.opt;
      // Standby one is not offered on detector modes
      if (s_r.ch[i].cfg.mode >= AOQ_MD_LOOP) begin
        if (op == AOQ_OPT_SB1) begin
          op = AOQ_OPT_STANDARD;
        end else if (op == AOQ_OPT_LATCH_SB1) begin
          op = AOQ_OPT_LATCH;
        end
      end
      lat = (op == AOQ_OPT_LATCH || op == AOQ_OPT_LATCH_SB1
        || op == AOQ_OPT_LATCH_SB2);
      sb = (op == AOQ_OPT_SB1 || op == AOQ_OPT_LATCH_SB1
        || op == AOQ_OPT_SB2 || op == AOQ_OPT_LATCH_SB2);
      // First compare after reset is not yet valid
      s_nxt.q[i].boot = 1'b0;
      // A clear condition ends any pending standby
      if (!s_r.q[i].boot && !cond[i]) begin
        s_nxt.q[i].pend = 1'b0;
      end
      // Judge by the option being written, so selecting standby two arms it
      if (rearm_c && (s_nxt.ch[i].cfg.opt == AOQ_OPT_SB2
          || s_nxt.ch[i].cfg.opt == AOQ_OPT_LATCH_SB2)) begin
        s_nxt.q[i].pend = 1'b1;
      end
      // Suppressed while a standby is pending
      qual = cond[i] && !(sb && s_r.q[i].pend);
      // New alarm wins over a same-cycle reset
      s_nxt.q[i].latched = lat
        && (qual || (s_r.q[i].latched && !clr_c));
      s_nxt.q[i].active = lat ? s_nxt.q[i].latched : qual;
      // Contact polarity; closed on alarm when normally open
      s_nxt.q[i].relay =
        s_nxt.q[i].active ^ s_nxt.ch[i].cfg.nc;
      s_nxt.q[i].led = s_nxt.q[i].active;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      for (int i = 0; i < 4; i++) begin
        s_r.ch[i].hi <= `AOQ_RST_SETVAL;
        s_r.ch[i].lo <= `AOQ_RST_SETVAL;
        s_r.ch[i].hyst <= `AOQ_RST_HYST;
        s_r.q[i].boot <= 1'b1;
        s_r.q[i].pend <= 1'b1;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  for (genvar g = 0; g < 4; g++) begin : g_out
    assign relay_close[g] = s_r.q[g].relay;
    assign indicator[g] = s_r.q[g].led;
  end

  // ----------------------------------------
  // Checks on channel zero; covers on channel zero and the bus
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_std;
    (s_r.ch[0].cfg.opt == AOQ_OPT_STANDARD) |=>
      (s_r.q[0].active == $past(cond[0]));
  endproperty
  a_std: assert property (p_std)
    else $error("standard output does not follow condition");

  property p_latch_hold;
    (s_r.ch[0].cfg.opt == AOQ_OPT_LATCH && s_r.q[0].active && !clr_c)
      |=> s_r.q[0].active;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched output dropped without reset");

  property p_release;
    (s_r.ch[0].cfg.opt == AOQ_OPT_LATCH && clr_c && !cond[0])
      |=> !s_r.q[0].active;
  endproperty
  a_release: assert property (p_release)
    else $error("latched output not released by reset");

  property p_sb1;
    (s_r.ch[0].cfg.opt == AOQ_OPT_SB1 && s_r.ch[0].cfg.mode < AOQ_MD_LOOP
      && s_r.q[0].pend) |=> !s_r.q[0].active;
  endproperty
  a_sb1: assert property (p_sb1)
    else $error("standby one did not suppress");

  property p_first;
    (!s_r.q[0].boot && !cond[0] && !rearm_c) |=> !s_r.q[0].pend;
  endproperty
  a_first: assert property (p_first)
    else $error("standby still pending with no condition");

  property p_rearm;
    (rearm_c && s_nxt.ch[0].cfg.opt == AOQ_OPT_LATCH_SB2) |=>
      s_r.q[0].pend ##1 (!s_r.q[0].latched || $past(s_r.q[0].latched));
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("standby two not re-armed");

  property p_extreme;
    modechg_c[0] |=> (s_r.ch[0].hi == ext_hi(s_r.ch[0].cfg.mode)
      && s_r.ch[0].lo == ext_lo(s_r.ch[0].cfg.mode));
  endproperty
  a_extreme: assert property (p_extreme)
    else $error("set values not loaded with extremes");

  property p_rst_val;
    $rose(aresetn) |-> (s_r.ch[0].hi == `AOQ_RST_SETVAL);
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("set value default wrong");

  property p_no;
    (s_r.q[0].active && !s_r.ch[0].cfg.nc) |-> relay_close[0];
  endproperty
  a_no: assert property (p_no)
    else $error("normally open contact not closed on alarm");

  property p_nc;
    (s_r.q[0].active && s_r.ch[0].cfg.nc) |-> !relay_close[0];
  endproperty
  a_nc: assert property (p_nc)
    else $error("normally closed contact not opened on alarm");

  property p_led;
    $rose(s_r.q[0].active) |-> indicator[0];
  endproperty
  a_led: assert property (p_led)
    else $error("indicator not lit on alarm");

  c_latch: cover property (s_r.q[0].latched ##1 clr_c ##1 !s_r.q[0].active);
  c_sb: cover property (s_r.q[0].pend && cond[0] ##1 !cond[0]);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // aoq_alarm_qualifier
`default_nettype wire

// >>> aoq_relay_load.sv
`default_nettype none
// ----------------------------------------
// Relay-driven alarm load, such as a buzzer
// ----------------------------------------
module aoq_relay_load (
  input wire logic [3:0] relay_close,
  output logic [3:0] sounding
);
  // Current flows, and the buzzer sounds, only through a closed contact
  assign sounding = relay_close;
endmodule // aoq_relay_load
`default_nettype wire

// >>> tb_alarm_output_qualifier.sv
`default_nettype none
module tb_alarm_output_qualifier;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 0, aresetn = 0, rst_pin = 0, run_pin = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] relay, led, snd;
  logic [3:0] brk = 0;
  aoq_pkg::aoq_meas_arr_t meas = '0;
  int fail_count = 0, check_count = 0, cyc_n = 0;

  always #2 aclk = ~aclk;

  // Prot is tied; one bench level feeds both break detector inputs
  aoq_alarm_qualifier u_aoq_alarm_qualifier (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .meas(meas), .loop_break(brk),
    .sensor_break(brk), .alarm_reset_pin(rst_pin), .run_pin(run_pin),
    .relay_close(relay), .indicator(led));

  aoq_relay_load u_aoq_relay_load (.relay_close(relay), .sounding(snd));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One AXI transfer; readies are sampled at the falling edge, where settled
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
    logic ka, kw, kr, dn;
    dn = 0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
    end else begin
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
    end
    while (!dn) begin
      @(negedge aclk);
      {ka, kw, kr} = {awready, wready, arready};
      dn = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge aclk);
      if (ka) awvalid <= 0;
      if (kw) wvalid <= 0;
      if (kr) arvalid <= 0;
      if (dn) begin
        bready <= 0;
        rready <= 0;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1, a, d, q, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic [1:0] r;
    bus(0, a, 0, q, r);
    chk(q, e);
  endtask

  // Generous wait covers the comparator, output and pin synchroniser stages
  task automatic settle();
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic pv(input int c, input logic signed [15:0] v);
    @(posedge aclk);
    meas[c].pv <= v;
    settle();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic [1:0] r;
    rc(8'h04, 32'h060e);
    rc(8'h0c, 32'h1);
    bus(0, 8'h4c, 0, q, r);
    chk(r, 2'h2);
    wr(8'h1c, 32'hc8);
    rc(8'h1c, 32'h64);
    rc(8'h0c, 32'h1);
    chk(snd, 4'h0);
    $display("test regs done");
  endtask

  task automatic t_std();
    wr(8'h00, 32'h05);
    rc(8'h04, 32'h7fff);
    wr(8'h04, 32'h64);
    pv(0, 101);
    chk({led[0], snd[0]}, 2'b11);
    pv(0, 100);
    chk(snd[0], 1'b1);
    pv(0, 99);
    chk({led[0], snd[0]}, 2'b00);
    $display("test standard done");
  endtask

  task automatic t_nc();
    wr(8'h10, 32'h85);
    wr(8'h14, 32'h64);
    pv(1, 0);
    chk({led[1], snd[1]}, 2'b01);
    pv(1, 101);
    chk({led[1], snd[1]}, 2'b10);
    chk(snd[0], 1'b0);
    $display("test polarity done");
  endtask

  task automatic t_latch();
    wr(8'h20, 32'h15);
    wr(8'h24, 32'h64);
    pv(2, 101);
    pv(2, 0);
    chk(snd[2], 1'b1);
    wr(8'h48, 32'h1);
    settle();
    chk(snd[2], 1'b0);
    pv(2, 101);
    pv(2, 0);
    chk(snd[2], 1'b1);
    @(posedge aclk);
    rst_pin <= 1;
    settle();
    chk(snd[2], 1'b0);
    @(posedge aclk);
    rst_pin <= 0;
    // No condition at power-up, so latch standby one acts at once
    wr(8'h20, 32'h35);
    wr(8'h24, 32'h64);
    pv(2, 101);
    pv(2, 0);
    chk(snd[2], 1'b1);
    $display("test latch done");
  endtask

  task automatic t_sb2();
    wr(8'h30, 32'h45);
    wr(8'h34, 32'h64);
    pv(3, 101);
    chk(snd[3], 1'b1);
    // Re-arm while the condition stands: suppressed until it clears
    wr(8'h34, 32'h64);
    settle();
    chk(snd[3], 1'b0);
    pv(3, 0);
    pv(3, 101);
    chk(snd[3], 1'b1);
    @(posedge aclk);
    run_pin <= 1;
    settle();
    chk(snd[3], 1'b0);
    $display("test standby done");
  endtask

  // Loop break passes straight through; heater uses the low value and band
  task automatic t_det();
    wr(8'h00, 32'h07);
    rc(8'h0c, 32'h0);
    @(posedge aclk);
    brk <= 4'h1;
    settle();
    chk(snd[0], 1'b1);
    @(posedge aclk);
    brk <= 4'h0;
    wr(8'h00, 32'h09);
    wr(8'h08, 32'h64);
    settle();
    chk(snd[0], 1'b1);
    @(posedge aclk);
    meas[0].heater <= 16'h0064;
    settle();
    chk(snd[0], 1'b1);
    @(posedge aclk);
    meas[0].heater <= 16'h0065;
    settle();
    chk(snd[0], 1'b0);
    $display("test detectors done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge aclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_std();
    t_nc();
    t_latch();
    t_sb2();
    t_det();
    test_done();
  end
endmodule // tb_alarm_output_qualifier
`default_nettype wire
